// ### design/i2cm_master.sv
// Module: hardware two-wire bus master with special function registers and shared pins
`timescale 1ns/1ns
`default_nettype none
module i2cm_master
   import i2cm_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic [7:0] sfrAddr,
   input  wire logic [7:0] sfrWrData,
   input  wire logic       sfrWr,
   input  wire logic       sfrRd,
   output logic [7:0]      sfrRdData,
   input  wire logic       pinOwnerSelect,
   input  wire logic       spiMosiOut,
   input  wire logic       spiMosiOe,
   input  wire logic       spiSclkOut,
   input  wire logic       spiSclkOe,
   input  wire logic       serialDataIn,
   output logic            serialDataOut,
   output logic            serialDataOe,
   output logic            serialClkOut,
   output logic            serialClkOe
);
   // ==========================================================
   // Registers
   i2cm_state_type state_r, state_nxt;
   logic [1:0] qtr_r, qtr_nxt;
   logic [2:0] bitCnt_r, bitCnt_nxt;
   logic [4:0] byteCnt_r, byteCnt_nxt;
   logic [7:0] shift_r, shift_nxt;
   logic [7:0] mode_r, mode_nxt;
   logic [7:0] addr_r, addr_nxt;
   logic [7:0] txBuf_r, txBuf_nxt;
   logic [7:0] rxBuf_r, rxBuf_nxt;
   logic       txFull_r, txFull_nxt;
   logic       noAck_r, noAck_nxt;
   logic       rxIrq_r, rxIrq_nxt;
   logic       txIrq_r, txIrq_nxt;
   logic       txErr_r, txErr_nxt;
   logic       startPend_r, startPend_nxt;
   logic       nackSeen_r, nackSeen_nxt;
   logic       sclDrv_r, sclDrv_nxt;
   logic       sdaDrv_r, sdaDrv_nxt;
   logic       sdaMeta_r, sdaSync_r;
   logic [7:0] rdData_r;

   // ==========================================================
   // Decode
   logic       twoWireEnable;
   logic [1:0] clockRateSelect;
   logic [4:0] readByteCount;
   logic       directionBit;
   logic       wrTx, wrMode, wrAddr, wrStat;
   logic       tick;
   logic       lastByte;
   logic [7:0] statusView;
   logic [7:0] rdMux;

   assign twoWireEnable   = mode_r[MODE_EN_BIT];
   assign clockRateSelect = mode_r[MODE_RATE_LSB +: 2];
   assign readByteCount   = mode_r[MODE_RCNT_LSB +: 5];
   assign directionBit    = addr_r[ADDR_DIR_BIT];
   assign wrTx   = sfrWr && sfrAddr == OFS_TX_BUF;
   assign wrMode = sfrWr && sfrAddr == OFS_MODE;
   assign wrAddr = sfrWr && sfrAddr == OFS_ADDR;
   assign wrStat = sfrWr && sfrAddr == OFS_STATUS;
   assign lastByte = (byteCnt_r == readByteCount);

   assign statusView = {state_r != ST_IDLE, noAck_r, rxIrq_r, txIrq_r, 3'h0, txErr_r};
   // Transmit buffer reads as zero: write-only
   assign rdMux = (sfrAddr == OFS_RX_BUF) ? rxBuf_r    :
                  (sfrAddr == OFS_MODE)   ? mode_r     :
                  (sfrAddr == OFS_ADDR)   ? addr_r     :
                  (sfrAddr == OFS_STATUS) ? statusView : RST_READ;

   // ==========================================================
   // Quarter-bit divider
   i2cm_tick_if tk ();
   assign tk.run  = twoWireEnable && state_r != ST_IDLE;
   assign tk.rate = clockRateSelect;
   assign tick    = tk.tick;

   i2cm_tick_gen u_tick (
      .clk (clk),
      .rst (rst),
      .tk  (tk)
   );

   // ==========================================================
   // Shared pins: open-drain, drive only a low level while pinOwnerSelect gives them to the master
   assign serialDataOut = pinOwnerSelect ? 1'b0 : spiMosiOut;
   assign serialDataOe  = pinOwnerSelect ? (!sdaDrv_r && twoWireEnable) : spiMosiOe;
   assign serialClkOut  = pinOwnerSelect ? 1'b0 : spiSclkOut;
   assign serialClkOe   = pinOwnerSelect ? (!sclDrv_r && twoWireEnable) : spiSclkOe;
   assign sfrRdData     = rdData_r;

   // ==========================================================
   // Sequencer and register updates
   always_comb begin
      state_nxt     = state_r;
      qtr_nxt       = qtr_r;
      bitCnt_nxt    = bitCnt_r;
      byteCnt_nxt   = byteCnt_r;
      shift_nxt     = shift_r;
      mode_nxt      = mode_r;
      addr_nxt      = addr_r;
      txBuf_nxt     = txBuf_r;
      rxBuf_nxt     = rxBuf_r;
      txFull_nxt    = txFull_r;
      noAck_nxt     = noAck_r;
      rxIrq_nxt     = rxIrq_r;
      txIrq_nxt     = txIrq_r;
      txErr_nxt     = txErr_r;
      startPend_nxt = startPend_r;
      nackSeen_nxt  = nackSeen_r;
      sclDrv_nxt    = sclDrv_r;
      sdaDrv_nxt    = sdaDrv_r;

      // Software side first so hardware sets below win over clears
      if (wrMode) begin
         mode_nxt = sfrWrData;
      end
      if (wrAddr) begin
         addr_nxt      = sfrWrData;
         startPend_nxt = 1'b1;
      end
      if (wrTx) begin
         if (txFull_r) begin
            txErr_nxt = 1'b1;
         end else begin
            txBuf_nxt  = sfrWrData;
            txFull_nxt = 1'b1;
            txIrq_nxt  = 1'b0;
         end
      end
      if (wrStat) begin
         noAck_nxt = noAck_r && sfrWrData[STAT_NOACK_BIT];
         rxIrq_nxt = rxIrq_r && sfrWrData[STAT_RXIRQ_BIT];
         txIrq_nxt = txIrq_r && sfrWrData[STAT_TXIRQ_BIT];
         txErr_nxt = txErr_r && sfrWrData[STAT_TXERR_BIT];
      end

      if (tick) begin
         qtr_nxt = qtr_r + 2'h1;
      end

      case (state_r)
         ST_IDLE: begin
            sclDrv_nxt = 1'b1;
            sdaDrv_nxt = 1'b1;
            qtr_nxt    = 2'h0;
            if (startPend_r && twoWireEnable) begin
               state_nxt     = ST_START;
               startPend_nxt = 1'b0;
            end
         end
         ST_START: begin
            if (tick) begin
               case (qtr_r)
                  2'h0:    sdaDrv_nxt = 1'b1;
                  2'h1:    sclDrv_nxt = 1'b1;
                  2'h2:    sdaDrv_nxt = 1'b0;
                  default: begin
                     sclDrv_nxt   = 1'b0;
                     shift_nxt    = addr_r;
                     bitCnt_nxt   = 3'h0;
                     nackSeen_nxt = 1'b0;
                     state_nxt    = ST_ADDR;
                  end
               endcase
            end
         end
         ST_ADDR, ST_WBYTE, ST_RBYTE: begin
            if (tick) begin
               case (qtr_r)
                  2'h0:    sdaDrv_nxt = (state_r == ST_RBYTE) ? 1'b1 : shift_r[7];
                  2'h1:    sclDrv_nxt = 1'b1;
                  2'h2:    shift_nxt  = {shift_r[6:0], sdaSync_r};
                  default: begin
                     sclDrv_nxt = 1'b0;
                     bitCnt_nxt = bitCnt_r + 3'h1;
                     if (bitCnt_r == BIT_LAST) begin
                        state_nxt = (state_r == ST_ADDR)  ? ST_AACK :
                                    (state_r == ST_WBYTE) ? ST_WACK : ST_RACK;
                     end
                  end
               endcase
            end
         end
         ST_AACK, ST_WACK: begin
            if (tick) begin
               case (qtr_r)
                  2'h0:    sdaDrv_nxt = 1'b1;
                  2'h1:    sclDrv_nxt = 1'b1;
                  2'h2: begin
                     if (sdaSync_r) begin
                        nackSeen_nxt = 1'b1;
                        noAck_nxt    = 1'b1;
                        if (!directionBit) begin
                           txFull_nxt = 1'b0;
                        end
                     end
                  end
                  default: begin
                     sclDrv_nxt = 1'b0;
                     bitCnt_nxt = 3'h0;
                     if (nackSeen_r) begin
                        state_nxt = ST_STOP;
                     end else if (state_r == ST_AACK && directionBit) begin
                        byteCnt_nxt = 5'h00;
                        state_nxt   = ST_RBYTE;
                     end else if (txFull_r) begin
                        shift_nxt  = txBuf_r;
                        txFull_nxt = 1'b0;
                        txIrq_nxt  = 1'b1;
                        state_nxt  = ST_WBYTE;
                     end else begin
                        state_nxt = startPend_r ? ST_START : ST_STOP;
                        startPend_nxt = 1'b0;
                     end
                  end
               endcase
            end
         end
         ST_RACK: begin
            if (tick) begin
               case (qtr_r)
                  2'h0: begin
                     rxBuf_nxt  = shift_r;
                     rxIrq_nxt  = 1'b1;
                     sdaDrv_nxt = lastByte;
                  end
                  2'h1:    sclDrv_nxt = 1'b1;
                  2'h2:    sclDrv_nxt = 1'b1;
                  default: begin
                     sclDrv_nxt  = 1'b0;
                     bitCnt_nxt  = 3'h0;
                     byteCnt_nxt = byteCnt_r + 5'h01;
                     if (lastByte) begin
                        state_nxt     = startPend_r ? ST_START : ST_STOP;
                        startPend_nxt = 1'b0;
                     end else begin
                        state_nxt = ST_RBYTE;
                     end
                  end
               endcase
            end
         end
         ST_STOP: begin
            if (tick) begin
               case (qtr_r)
                  2'h0:    sdaDrv_nxt = 1'b0;
                  2'h1:    sclDrv_nxt = 1'b1;
                  2'h2:    sdaDrv_nxt = 1'b1;
                  default: state_nxt  = startPend_r ? ST_START : ST_IDLE;
               endcase
            end
         end
         default: state_nxt = ST_IDLE;
      endcase

      // Disabling abandons the transfer and releases both lines
      if (!twoWireEnable) begin
         state_nxt     = ST_IDLE;
         sclDrv_nxt    = 1'b1;
         sdaDrv_nxt    = 1'b1;
         startPend_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      sdaMeta_r <= serialDataIn;
      sdaSync_r <= sdaMeta_r;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdData_r <= RST_READ;
      end else if (sfrRd) begin
         rdData_r <= rdMux;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r     <= ST_IDLE;
         qtr_r       <= 2'h0;
         bitCnt_r    <= 3'h0;
         byteCnt_r   <= 5'h00;
         shift_r     <= RST_READ;
         mode_r      <= RST_MODE;
         addr_r      <= RST_ADDR;
         txBuf_r     <= RST_TXBUF;
         rxBuf_r     <= RST_RXBUF;
         txFull_r    <= 1'b0;
         noAck_r     <= 1'b0;
         rxIrq_r     <= 1'b0;
         txIrq_r     <= 1'b0;
         txErr_r     <= 1'b0;
         startPend_r <= 1'b0;
         nackSeen_r  <= 1'b0;
         sclDrv_r    <= 1'b1;
         sdaDrv_r    <= 1'b1;
      end else begin
         state_r     <= state_nxt;
         qtr_r       <= qtr_nxt;
         bitCnt_r    <= bitCnt_nxt;
         byteCnt_r   <= byteCnt_nxt;
         shift_r     <= shift_nxt;
         mode_r      <= mode_nxt;
         addr_r      <= addr_nxt;
         txBuf_r     <= txBuf_nxt;
         rxBuf_r     <= rxBuf_nxt;
         txFull_r    <= txFull_nxt;
         noAck_r     <= noAck_nxt;
         rxIrq_r     <= rxIrq_nxt;
         txIrq_r     <= txIrq_nxt;
         txErr_r     <= txErr_nxt;
         startPend_r <= startPend_nxt;
         nackSeen_r  <= nackSeen_nxt;
         sclDrv_r    <= sclDrv_nxt;
         sdaDrv_r    <= sdaDrv_nxt;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_addr_kick;
      wrAddr && twoWireEnable && state_r == ST_IDLE && !startPend_r;
   endsequence
   sequence s_ack_missed;
      (state_r == ST_AACK || state_r == ST_WACK) && tick && qtr_r == 2'h2 && sdaSync_r;
   endsequence

   chk_addr_start: assert property (s_addr_kick |-> ##2 state_r == ST_START)
      else $error("address write did not start");
   chk_open_drain: assert property (pinOwnerSelect |-> !serialDataOut && !serialClkOut)
      else $error("line driven high");
   chk_pin_owner: assert property (!pinOwnerSelect |-> serialDataOe == spiMosiOe
      && serialClkOe == spiSclkOe) else $error("pins not handed to SPI");
   chk_disable_idle: assert property (!twoWireEnable |=> state_r == ST_IDLE && sclDrv_r)
      else $error("disabled master still active");
   chk_noack_flag: assert property (s_ack_missed |=> noAck_r && nackSeen_r)
      else $error("missing acknowledge not flagged");
   chk_noack_flush: assert property ((s_ack_missed and !directionBit) |=> !txFull_r)
      else $error("transmit data not flushed");
   chk_nack_stop: assert property (nackSeen_r && state_r == ST_AACK && tick
      && qtr_r == QTR_LAST |=> state_r == ST_STOP) else $error("no stop on error");
   chk_last_nack: assert property (state_r == ST_RACK && qtr_r == 2'h1 |-> sdaDrv_r == lastByte)
      else $error("wrong read acknowledge");
   chk_restart: assert property (state_r == ST_RACK && lastByte && startPend_r && tick
      && qtr_r == QTR_LAST |=> state_r == ST_START) else $error("no repeated start");
   chk_start_edge: assert property (state_r == ST_START && tick && qtr_r == 2'h2
      |=> sclDrv_r && !sdaDrv_r) else $error("bad start condition");
   chk_rate_quarter: assert property (tick && qtr_r != QTR_LAST && clockRateSelect == 2'h0
      && twoWireEnable |=> (!tick)[*3] ##1 tick) else $error("fast rate wrong");

endmodule : i2cm_master
`default_nettype wire

// ### design/i2cm_pkg.sv
// Package: register map, field layout, reset values, timing and states of the two-wire master
package i2cm_pkg;

   // ==========================================================
   // Register offsets on the special function register bus
   localparam logic [7:0] OFS_TX_BUF    = 8'h9A;
   localparam logic [7:0] OFS_RX_BUF    = 8'h9B;
   localparam logic [7:0] OFS_MODE      = 8'hE8;
   localparam logic [7:0] OFS_ADDR      = 8'hE9;
   localparam logic [7:0] OFS_STATUS    = 8'hEA;

   // ==========================================================
   // Field positions
   localparam int MODE_EN_BIT     = 7;
   localparam int MODE_RATE_LSB   = 5;
   localparam int MODE_RCNT_LSB   = 0;
   localparam int ADDR_DIR_BIT    = 0;
   localparam int STAT_BUSY_BIT   = 7;
   localparam int STAT_NOACK_BIT  = 6;
   localparam int STAT_RXIRQ_BIT  = 5;
   localparam int STAT_TXIRQ_BIT  = 4;
   localparam int STAT_TXERR_BIT  = 0;

   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_MODE   = 8'h00;
   localparam logic [7:0] RST_ADDR   = 8'h00;
   localparam logic [7:0] RST_RXBUF  = 8'h00;
   localparam logic [7:0] RST_TXBUF  = 8'h00;
   localparam logic [7:0] RST_READ   = 8'h00;

   // ==========================================================
   // Timing: one serial clock period is 16 << rate core cycles, split in four quarters
   localparam int             SCL_BASE_DIV = 16;
   localparam int             QUARTERS     = 4;
   localparam int             QTR_CNT_W    = 6;
   localparam logic [QTR_CNT_W-1:0] QTR_BASE = QTR_CNT_W'(SCL_BASE_DIV / QUARTERS);
   localparam logic [1:0]     QTR_LAST     = 2'h3;
   localparam logic [2:0]     BIT_LAST     = 3'h7;

   // ==========================================================
   // Sequencer states
   typedef enum logic [3:0] {
      ST_IDLE, ST_START, ST_ADDR, ST_AACK, ST_WBYTE, ST_WACK, ST_RBYTE, ST_RACK, ST_STOP
   } i2cm_state_type;

endpackage : i2cm_pkg

// ### design/i2cm_tick_if.sv
// Interface: quarter-bit tick request and pulse between sequencer and divider
`timescale 1ns/1ns
`default_nettype none
interface i2cm_tick_if;
   logic       run;
   logic [1:0] rate;
   logic       tick;
   modport gen  (input run, input rate, output tick);
   modport user (output run, output rate, input tick);
endinterface : i2cm_tick_if
`default_nettype wire

// ### design/i2cm_tick_gen.sv
// Module: divider making one-cycle quarter-bit enable pulses from the core clock
`timescale 1ns/1ns
`default_nettype none
module i2cm_tick_gen
   import i2cm_pkg::*;
(
   input  wire logic    clk,
   input  wire logic    rst,
   i2cm_tick_if.gen     tk
);
   logic [QTR_CNT_W-1:0] cnt_r;
   logic [QTR_CNT_W-1:0] limit;
   logic                 atLimit;

   // Quarter length is (16 << rate) / 4 core cycles
   assign limit   = (QTR_BASE << tk.rate) - QTR_CNT_W'(1);
   assign atLimit = (cnt_r == limit);
   assign tk.tick = tk.run && atLimit;

   always_ff @(posedge clk) begin
      if (rst || !tk.run || atLimit) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + QTR_CNT_W'(1);
      end
   end

   chk_tick_spacing: assert property (@(posedge clk) disable iff (rst)
      (tk.tick && tk.rate == 2'h1) |=> (!tk.tick)[*7]) else $error("tick too early");

endmodule : i2cm_tick_gen
`default_nettype wire

// ### verification/i2cm_slave_model.sv
// Slave model for the two-wire master: acks on command, returns read data, logs traffic
`timescale 1ns/1ns
`default_nettype none
module i2cm_slave_model (
   input  wire logic       sda,
   input  wire logic       scl,
   input  wire logic       ackOn,
   input  wire logic [7:0] rdData,
   output logic            pullLow,
   output logic [7:0]      addrByte,
   output logic [7:0]      wrByte,
   output logic [7:0]      ackLog,
   output int              stopCnt
);
   int i;
   initial begin
      pullLow = 0;
      ackLog = 8'hFF;
      stopCnt = 0;
      forever begin
         @(negedge sda iff scl);
         for (i = 0; i < 8; i++) begin
            @(posedge scl);
            addrByte = {addrByte[6:0], sda};
         end
         @(negedge scl);
         pullLow = ackOn;
         @(negedge scl);
         pullLow = 0;
         if (ackOn && addrByte[0]) begin
            do begin
               for (i = 0; i < 8; i++) begin
                  pullLow = !rdData[7-i];
                  @(negedge scl);
               end
               pullLow = 0;
               @(posedge scl);
               ackLog = {ackLog[6:0], sda};
               @(negedge scl);
            end while (!ackLog[0]);
         end else if (ackOn) begin
            for (i = 0; i < 8; i++) begin
               @(posedge scl);
               wrByte = {wrByte[6:0], sda};
            end
            @(negedge scl);
            pullLow = 1;
            @(negedge scl);
            pullLow = 0;
         end
      end
   end
   always @(posedge sda) if (scl) stopCnt++;
endmodule : i2cm_slave_model
`default_nettype wire

// ### verification/tb_i2cm_master.sv
// Testbench for the two-wire master: registers and bus transfers against a slave model
`timescale 1ns/1ns
`default_nettype none
module tb_i2cm_master;
   import i2cm_pkg::*;
   logic       clk, rst, sfrWr, sfrRd, owner, mosiOut, mosiOe, sclkOut, sclkOe;
   logic [7:0] sfrAddr, sfrWrData, sfrRdData, rd, addrByte, wrByte, ackLog, rxVal;
   logic       dOut, dOe, cOut, cOe, pullLow, ackOn;
   int         stopCnt, s0, n_fail, n_compared;
   wire logic  sda = !(dOe && !dOut) && !pullLow;
   wire logic  scl = !(cOe && !cOut);

   i2cm_master u_i2cm_master (.clk(clk), .rst(rst), .sfrAddr(sfrAddr),
      .sfrWrData(sfrWrData), .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrRdData(sfrRdData),
      .pinOwnerSelect(owner), .spiMosiOut(mosiOut), .spiMosiOe(mosiOe),
      .spiSclkOut(sclkOut), .spiSclkOe(sclkOe), .serialDataIn(sda),
      .serialDataOut(dOut), .serialDataOe(dOe), .serialClkOut(cOut), .serialClkOe(cOe));
   i2cm_slave_model u_i2cm_slave_model (.sda(sda), .scl(scl), .ackOn(ackOn),
      .rdData(rxVal), .pullLow(pullLow), .addrByte(addrByte), .wrByte(wrByte),
      .ackLog(ackLog), .stopCnt(stopCnt));

   // ==========================================================
   // Helpers
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfrAddr = a;
      sfrWrData = d;
      sfrWr = 1;
      @(negedge clk);
      sfrWr = 0;
      @(negedge clk);
   endtask : wr
   task automatic rdr(input logic [7:0] a);
      sfrAddr = a;
      sfrRd = 1;
      @(negedge clk);
      sfrRd = 0;
      rd = sfrRdData;
      @(negedge clk);
   endtask : rdr
   task automatic per(input int n);
      time t;
      @(posedge scl);
      t = $time;
      @(posedge scl);
      chk(8'((($time - t) / 10) - n), 8'h00, "scl period");
      @(negedge clk);
   endtask : per
   task automatic wait_idle();
      repeat (4) @(negedge clk);
      for (int k = 0; k < 3000; k++) begin
         rdr(OFS_STATUS);
         if (rd[STAT_BUSY_BIT] === 1'b0) break;
      end
      chk({7'h00, rd[STAT_BUSY_BIT]}, 8'h00, "busy");
   endtask : wait_idle
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      logic [7:0] ofs [5] = '{OFS_TX_BUF, OFS_RX_BUF, OFS_MODE, OFS_ADDR, OFS_STATUS};
      wr(OFS_RX_BUF, 8'h55);
      foreach (ofs[j]) begin
         rdr(ofs[j]);
         chk(rd, 8'h00, "reset value");
      end
      rdr(8'h00);
      chk(rd, 8'h00, "unmapped");
      $display("done reset");
   endtask : t_reset
   task automatic t_write();
      ackOn = 1;
      s0 = stopCnt;
      wr(OFS_MODE, 8'h80);
      wr(OFS_TX_BUF, 8'hA5);
      wr(OFS_ADDR, 8'hA0);
      per(16);
      wait_idle();
      chk(addrByte, 8'hA0, "address byte");
      chk(wrByte, 8'hA5, "data byte");
      chk(8'(stopCnt - s0), 8'h01, "stop count");
      rdr(OFS_STATUS);
      chk(rd & 8'hD0, 8'h10, "write status");
      $display("done write");
   endtask : t_write
   task automatic t_read();
      rxVal = 8'h3C;
      s0 = stopCnt;
      wr(OFS_MODE, 8'hA1);
      wr(OFS_ADDR, 8'hA1);
      per(32);
      wr(OFS_ADDR, 8'hA1);
      wait_idle();
      chk(ackLog, 8'hF5, "acks");
      chk(8'(stopCnt - s0), 8'h01, "restart stop count");
      chk(addrByte, 8'hA1, "restart address");
      rdr(OFS_RX_BUF);
      chk(rd, 8'h3C, "rx byte");
      rdr(OFS_STATUS);
      chk(rd & 8'h60, 8'h20, "read status");
      $display("done read");
   endtask : t_read
   task automatic t_nack();
      ackOn = 0;
      wr(OFS_TX_BUF, 8'h5A);
      for (int r = 2; r < 4; r++) begin
         s0 = stopCnt;
         wr(OFS_MODE, 8'h80 | 8'(r << MODE_RATE_LSB));
         wr(OFS_ADDR, 8'hA0);
         per(16 << r);
         wait_idle();
         chk(8'(stopCnt - s0), 8'h01, "nack stop");
         rdr(OFS_STATUS);
         chk(rd & 8'h40, 8'h40, "nack set");
         wr(OFS_STATUS, 8'h00);
         wr(OFS_TX_BUF, 8'h5A);
         rdr(OFS_STATUS);
         chk(rd & 8'h41, 8'h00, "nack clear, tx flushed");
      end
      $display("done nack");
   endtask : t_nack
   task automatic t_disabled();
      s0 = stopCnt;
      wr(OFS_MODE, 8'h00);
      wr(OFS_ADDR, 8'hA0);
      repeat (300) @(negedge clk);
      chk(8'(stopCnt - s0), 8'h00, "disabled");
      chk({7'h00, scl}, 8'h01, "scl idle");
      $display("done disabled");
   endtask : t_disabled
   task automatic t_pins();
      owner = 0;
      @(negedge clk);
      chk({4'h0, dOut, dOe, cOut, cOe}, 8'h0D, "spi owns");
      owner = 1;
      @(negedge clk);
      chk({4'h0, dOut, dOe, cOut, cOe}, 8'h00, "open drain");
      $display("done pins");
   endtask : t_pins

   // ==========================================================
   // Clock, watchdog, sequence
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   initial begin
      #500000;
      n_fail++;
      test_done();
   end
   initial begin
      {rst, sfrWr, sfrRd, ackOn} = 4'h9;
      {sfrAddr, sfrWrData, rxVal} = 24'h000000;
      {owner, mosiOut, mosiOe, sclkOut, sclkOe} = 5'h1D;
      n_fail = 0;
      n_compared = 0;
      repeat (3) @(negedge clk);
      rst = 0;
      t_reset();
      t_write();
      t_read();
      t_nack();
      t_disabled();
      t_pins();
      test_done();
   end
endmodule : tb_i2cm_master
`default_nettype wire
